// >>> hdl/fpb_map.svh
`ifndef FPB_MAP_SVH
`define FPB_MAP_SVH

// widths and geometry defaults
`define FPB_ADDR_W        18
`define FPB_BLOCK_BYTES   16
`define FPB_PAGE_BLOCKS   8
`define FPB_PAGE_COUNT    64
`define FPB_FETCH_CYC     8

// access width codes
`define FPB_WID_BYTE      2'h0
`define FPB_WID_HALF      2'h1

// status codes
`define FPB_ST_OK         2'h0
`define FPB_ST_LOCKED     2'h1
`define FPB_ST_RETAIN     2'h3

// status register bits
`define FPB_EV_DONE       0
`define FPB_EV_LOCKED     1
`define FPB_EV_RETAIN     2
`define FPB_EV_W          3

`endif

// >>> hdl/fpb_pkg.sv
package fpb_pkg;

    typedef enum logic [2:0] {
        FPB_OP_INIT,
        FPB_OP_RESET,
        FPB_OP_READ,
        FPB_OP_WRITE,
        FPB_OP_ERASE,
        FPB_OP_PROGRAM,
        FPB_OP_UNPROTECT,
        FPB_OP_DISCARD
    } fpb_op_t;

    typedef enum logic [2:0] {
        FPB_S_IDLE,
        FPB_S_FETCH,
        FPB_S_MERGE,
        FPB_S_COMMIT,
        FPB_S_JTAG
    } fpb_state_t;

    typedef struct packed {
        logic [7:0]  req;
        logic [17:0] addr;
        logic [1:0]  width;
        logic [31:0] wdata;
        logic        retain_guard;
        logic        write_lock_set;
    } fpb_req_t;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic [1:0]  status;
        logic [31:0] rdata;
    } fpb_rsp_t;

endpackage

// >>> hdl/fpb_core.sv
// Contract
// - transfers are one to four bytes wide
// - write to unbuffered page fetches whole page
// - write loads block buffer then merges data
// - block buffer copied into page buffer
// - same-block writes update both, no reload
// - other block in page loads from page
// - width code 00/01/1x selects 1/2/4 bytes
// - byte is smallest addressable unit
// - ignore low address bits for wider accesses
// - guard refuses writes to other pages
// - refused guarded write reports status 11
// - locked page refuses write/program/erase, status 01
// - program with lock input marks page locked
// - unprotect then program unlocked clears lock
// - user hold stalls jtag side accesses
// - simultaneous requests served by fixed priority
`include "fpb_map.svh"

module fpb_core #(
    parameter int BLOCK_BYTES = `FPB_BLOCK_BYTES,
    parameter int PAGE_BLOCKS = `FPB_PAGE_BLOCKS,
    parameter int PAGE_COUNT  = `FPB_PAGE_COUNT
) (
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    input  wire fpb_pkg::fpb_req_t req_i,
    input  wire logic              user_port_hold_i,
    input  wire logic              jtag_req_i,
    output logic                   jtag_grant_o,
    output fpb_pkg::fpb_rsp_t      rsp_o,
    // avalon-mm register slave
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    output logic                   irq_o
);
    localparam int PAGE_BYTES = BLOCK_BYTES * PAGE_BLOCKS;
    localparam int BOFS_W     = $clog2(BLOCK_BYTES);
    localparam int BLK_W      = $clog2(PAGE_BLOCKS);
    localparam int PAGE_W     = $clog2(PAGE_COUNT);
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_MASK   = 4'h1;
    localparam logic [3:0] REG_INFO   = 4'h2;

    // flash array, page buffer and block buffer
    logic [7:0] array_mem [PAGE_COUNT*PAGE_BYTES];
    logic [7:0] page_buf  [PAGE_BYTES];
    logic [7:0] block_buf [BLOCK_BYTES];

    typedef struct packed {
        fpb_pkg::fpb_state_t   state;
        fpb_pkg::fpb_op_t      op;
        logic [PAGE_W-1:0]     cur_page;
        logic                  page_valid;
        logic [BLK_W-1:0]      cur_block;
        logic                  block_valid;
        logic [PAGE_W-1:0]     tgt_page;
        logic [BLK_W-1:0]      tgt_block;
        logic [BOFS_W-1:0]     tgt_ofs;
        logic [1:0]            width;
        logic [31:0]           wdata;
        logic                  lock_in;
        logic [7:0]            cnt;
        logic [PAGE_COUNT-1:0] locked;
        logic                  busy;
        logic                  done;
        logic [1:0]            status;
        logic [31:0]           rdata;
        logic                  jtag_grant;
        logic [`FPB_EV_W-1:0]  ev;
        logic [`FPB_EV_W-1:0]  mask;
        logic [31:0]           avs_rd;
        logic                  avs_ack;
        logic                  irq;
    } fpb_st_t;

    fpb_st_t st, next_st;

    // picks the lowest-numbered request
    function automatic logic [3:0] fpb_pick(input logic [7:0] r);
        logic [3:0] p;
        p = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (r[i]) begin
                p = 4'(i);
            end
        end
        return p;
    endfunction

    // byte count from width code
    function automatic int fpb_nbytes(input logic [1:0] w);
        int n;
        n = (w == `FPB_WID_BYTE) ? 1 : (w == `FPB_WID_HALF) ? 2 : 4;
        return n;
    endfunction

    // offset with ignored low bits cleared
    function automatic logic [BOFS_W-1:0] fpb_align(input logic [BOFS_W-1:0] o, input logic [1:0] w);
        logic [BOFS_W-1:0] a;
        a = o;
        if (w != `FPB_WID_BYTE) begin
            a[0] = 1'b0;
        end
        if (w[1]) begin
            a[1] = 1'b0;
        end
        return a;
    endfunction

    logic [3:0]        pick;
    logic [PAGE_W-1:0] a_page;
    logic [BLK_W-1:0]  a_block;
    logic [BOFS_W-1:0] a_ofs;
    logic              hit_page;

    always_comb begin
        pick     = fpb_pick(req_i.req);
        a_ofs    = fpb_align(req_i.addr[BOFS_W-1:0], req_i.width);
        a_block  = req_i.addr[BOFS_W +: BLK_W];
        a_page   = req_i.addr[BOFS_W+BLK_W +: PAGE_W];
        hit_page = st.page_valid && (st.cur_page == a_page);
    end

    always_comb begin
        logic [`FPB_EV_W-1:0] set_ev;
        logic [`FPB_EV_W-1:0] clr_ev;
        logic                 acc;
        logic [31:0]          rd;
        set_ev  = '0;
        clr_ev  = '0;
        rd      = '0;
        acc     = 1'b0;
        next_st = st;
        next_st.done = 1'b0;
        unique case (st.state)
            fpb_pkg::FPB_S_IDLE: begin
                if (jtag_req_i && !user_port_hold_i && pick == 4'h8) begin
                    next_st.state      = fpb_pkg::FPB_S_JTAG;
                    next_st.jtag_grant = 1'b1;
                    next_st.busy       = 1'b1;
                end else if (pick != 4'h8) begin
                    next_st.op        = fpb_pkg::fpb_op_t'(pick[2:0]);
                    next_st.tgt_page  = a_page;
                    next_st.tgt_block = a_block;
                    next_st.tgt_ofs   = a_ofs;
                    next_st.width     = req_i.width;
                    next_st.wdata     = req_i.wdata;
                    next_st.lock_in   = req_i.write_lock_set;
                    next_st.busy      = 1'b1;
                    next_st.status    = `FPB_ST_OK;
                    next_st.state     = fpb_pkg::FPB_S_COMMIT;
                    next_st.cnt       = '0;
                    unique case (pick[2:0])
                        3'h3: begin
                            if (st.locked[a_page]) begin
                                next_st.status = `FPB_ST_LOCKED;
                            end else if (req_i.retain_guard && st.page_valid && !hit_page) begin
                                next_st.status = `FPB_ST_RETAIN;
                            end else if (!hit_page) begin
                                next_st.state = fpb_pkg::FPB_S_FETCH;
                            end else begin
                                next_st.state = fpb_pkg::FPB_S_MERGE;
                            end
                        end
                        3'h4, 3'h5: begin
                            if (st.locked[a_page]) begin
                                next_st.status = `FPB_ST_LOCKED;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            fpb_pkg::FPB_S_FETCH: begin
                next_st.cnt = st.cnt + 8'h1;
                if (st.cnt == 8'(`FPB_FETCH_CYC - 1)) begin
                    next_st.page_valid  = 1'b1;
                    next_st.cur_page    = st.tgt_page;
                    next_st.block_valid = 1'b0;
                    next_st.state       = fpb_pkg::FPB_S_MERGE;
                end
            end
            fpb_pkg::FPB_S_MERGE: begin
                next_st.cur_block   = st.tgt_block;
                next_st.block_valid = 1'b1;
                next_st.state       = fpb_pkg::FPB_S_COMMIT;
            end
            fpb_pkg::FPB_S_COMMIT: begin
                next_st.busy  = 1'b0;
                next_st.done  = 1'b1;
                next_st.state = fpb_pkg::FPB_S_IDLE;
                set_ev[`FPB_EV_DONE] = 1'b1;
                set_ev[`FPB_EV_LOCKED] = (st.status == `FPB_ST_LOCKED);
                set_ev[`FPB_EV_RETAIN] = (st.status == `FPB_ST_RETAIN);
                if (st.status == `FPB_ST_OK) begin
                    unique case (st.op)
                        fpb_pkg::FPB_OP_INIT, fpb_pkg::FPB_OP_RESET, fpb_pkg::FPB_OP_DISCARD: begin
                            next_st.page_valid  = 1'b0;
                            next_st.block_valid = 1'b0;
                        end
                        fpb_pkg::FPB_OP_READ: begin
                            for (int i = 0; i < 4; i++) begin
                                if (i < fpb_nbytes(st.width)) begin
                                    rd[i*8 +: 8] = hit_tgt() ? page_buf[st.tgt_block*BLOCK_BYTES
                                        + int'(st.tgt_ofs) + i]
                                        : array_mem[tgt_base() + int'(st.tgt_ofs) + i];
                                end
                            end
                            next_st.rdata = rd;
                        end
                        fpb_pkg::FPB_OP_PROGRAM: begin
                            next_st.locked[st.tgt_page] = st.lock_in;
                            next_st.page_valid  = 1'b0;
                            next_st.block_valid = 1'b0;
                        end
                        fpb_pkg::FPB_OP_UNPROTECT: begin
                            next_st.locked[st.tgt_page] = 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            fpb_pkg::FPB_S_JTAG: begin
                if (!jtag_req_i) begin
                    next_st.jtag_grant = 1'b0;
                    next_st.busy       = 1'b0;
                    next_st.state      = fpb_pkg::FPB_S_IDLE;
                end
            end
        endcase

        // register slave, one wait cycle then acknowledge
        acc = (avs_read || avs_write) && !st.avs_ack;
        next_st.avs_ack = acc;
        if (acc && avs_write && avs_byteenable[0]) begin
            if (avs_address == REG_STATUS) begin
                clr_ev = avs_writedata[`FPB_EV_W-1:0];
            end else if (avs_address == REG_MASK) begin
                next_st.mask = avs_writedata[`FPB_EV_W-1:0];
            end
        end
        if (acc && avs_read) begin
            unique case (avs_address)
                REG_STATUS: next_st.avs_rd = {29'h0, st.ev};
                REG_MASK:   next_st.avs_rd = {29'h0, st.mask};
                REG_INFO:   next_st.avs_rd = {28'h0, st.page_valid, st.status, st.busy};
                default:    next_st.avs_rd = 32'h0;
            endcase
        end
        // a new event wins over a clear in the same cycle
        next_st.ev  = (st.ev & ~clr_ev) | set_ev;
        // a set mask bit silences that event
        next_st.irq = |(next_st.ev & ~next_st.mask);
    end

    function automatic logic hit_tgt();
        return st.page_valid && st.cur_page == st.tgt_page;
    endfunction

    function automatic int tgt_base();
        return int'(st.tgt_page) * PAGE_BYTES;
    endfunction

    // buffer and array storage moves
    always_ff @(posedge clk_i) begin
        if (st.state == fpb_pkg::FPB_S_FETCH) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                page_buf[i] <= array_mem[tgt_base() + i];
            end
        end
        if (st.state == fpb_pkg::FPB_S_MERGE) begin
            for (int i = 0; i < BLOCK_BYTES; i++) begin
                logic [7:0] b;
                b = (st.block_valid && st.cur_block == st.tgt_block)
                    ? block_buf[i] : page_buf[st.tgt_block*BLOCK_BYTES + i];
                for (int k = 0; k < 4; k++) begin
                    if (k < fpb_nbytes(st.width) && i == int'(st.tgt_ofs) + k) begin
                        b = st.wdata[k*8 +: 8];
                    end
                end
                block_buf[i] <= b;
                page_buf[st.tgt_block*BLOCK_BYTES + i] <= b;
            end
        end
        if (st.state == fpb_pkg::FPB_S_COMMIT && st.status == `FPB_ST_OK) begin
            if (st.op == fpb_pkg::FPB_OP_ERASE) begin
                for (int i = 0; i < PAGE_BYTES; i++) begin
                    array_mem[tgt_base() + i] <= 8'h00;
                end
            end else if (st.op == fpb_pkg::FPB_OP_PROGRAM && hit_tgt()) begin
                for (int i = 0; i < PAGE_BYTES; i++) begin
                    array_mem[tgt_base() + i] <= page_buf[i];
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st       <= '0;
            st.state <= fpb_pkg::FPB_S_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign jtag_grant_o    = st.jtag_grant;
    assign rsp_o.busy      = st.busy;
    assign rsp_o.done      = st.done;
    assign rsp_o.status    = st.status;
    assign rsp_o.rdata     = st.rdata;
    assign avs_readdata    = st.avs_rd;
    assign avs_waitrequest = !st.avs_ack;
    assign irq_o           = st.irq;

    a_hold_blocks_jtag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (user_port_hold_i && !st.jtag_grant) |=> !st.jtag_grant)
        else $error("jtag granted under user hold");
    a_locked_status: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == fpb_pkg::FPB_S_IDLE && !(jtag_req_i && !user_port_hold_i) && req_i.req[7:3] == 5'h01
         && req_i.req[2:0] == 3'h0 && st.locked[a_page]) |=> ##1 (st.done && st.status == `FPB_ST_LOCKED))
        else $error("locked page write not refused with 01");
    a_retain_status: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == fpb_pkg::FPB_S_IDLE && !(jtag_req_i && !user_port_hold_i) && req_i.req[3:0] == 4'h8
         && !st.locked[a_page] && req_i.retain_guard && st.page_valid && !hit_page)
        |=> ##1 (st.done && st.status == `FPB_ST_RETAIN))
        else $error("guarded write not refused with 11");
    a_fetch_length: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(st.state == fpb_pkg::FPB_S_FETCH) |-> (st.state == fpb_pkg::FPB_S_FETCH) [*8]
        ##1 st.state == fpb_pkg::FPB_S_MERGE)
        else $error("page fetch not eight cycles");
    a_merge_syncs: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st.state == fpb_pkg::FPB_S_MERGE |=> st.block_valid && st.cur_block == $past(st.tgt_block))
        else $error("block buffer not tracked");
    a_hit_no_fetch: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == fpb_pkg::FPB_S_IDLE && pick == 4'h3 && hit_page && !st.locked[a_page]
         && !(jtag_req_i && !user_port_hold_i)) |=> st.state == fpb_pkg::FPB_S_MERGE)
        else $error("buffered page reloaded");
    a_busy_done: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        st.done |-> !st.busy && $past(st.busy))
        else $error("done without busy");
    a_irq_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ##1 irq_o == |(st.ev & ~st.mask))
        else $error("irq does not follow status and mask");
    a_priority_pick: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == fpb_pkg::FPB_S_IDLE && req_i.req[2] && req_i.req[3] && req_i.req[1:0] == 2'h0
         && !(jtag_req_i && !user_port_hold_i)) |=> st.op == fpb_pkg::FPB_OP_READ)
        else $error("priority order broken");
    a_program_lock: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == fpb_pkg::FPB_S_COMMIT && st.op == fpb_pkg::FPB_OP_PROGRAM && st.status == `FPB_ST_OK)
        |=> st.locked[$past(st.tgt_page)] == $past(st.lock_in))
        else $error("program did not record lock");
    a_unprotect_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == fpb_pkg::FPB_S_COMMIT && st.op == fpb_pkg::FPB_OP_UNPROTECT && st.status == `FPB_ST_OK)
        |=> !st.locked[$past(st.tgt_page)])
        else $error("unprotect left page locked");
    a_miss_fetches: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == fpb_pkg::FPB_S_IDLE && pick == 4'h3 && !hit_page && !st.locked[a_page]
         && !(req_i.retain_guard && st.page_valid) && !(jtag_req_i && !user_port_hold_i))
        |=> st.state == fpb_pkg::FPB_S_FETCH)
        else $error("unbuffered page not fetched");
    a_program_refused: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == fpb_pkg::FPB_S_IDLE && pick == 4'h5 && st.locked[a_page]
         && !(jtag_req_i && !user_port_hold_i)) |=> ##1 (st.done && st.status == `FPB_ST_LOCKED))
        else $error("locked page program not refused with 01");
    a_busy_taken: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        (st.state == fpb_pkg::FPB_S_IDLE && pick != 4'h8) |=> st.busy)
        else $error("accepted operation not busy");

endmodule // fpb_core

// >>> verification/fpb_jtag_model.sv
// jtag-side requester: asks once per want, holds request until granted, owns four cycles
module fpb_jtag_model (
    input  wire logic       clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       want_i,
    input  wire logic       grant_i,
    output logic            jtag_req_o,
    output logic [3:0]      served_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] own_cnt;
    logic       fin;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            jtag_req_o <= 1'b0;
            own_cnt    <= 2'h0;
            fin        <= 1'b0;
            served_o   <= 4'h0;
        end else if (!jtag_req_o) begin
            // one request per want, so a stalled grant is never mistaken for a second access
            if (want_i && !fin) jtag_req_o <= 1'b1;
            if (!want_i) fin <= 1'b0;
        end else if (grant_i) begin
            own_cnt <= own_cnt + 2'h1;
            if (own_cnt == 2'h3) begin
                jtag_req_o <= 1'b0;
                fin        <= 1'b1;
                served_o   <= served_o + 4'h1;
            end
        end
    end
endmodule // fpb_jtag_model

// >>> verification/flash_page_buffer_access_bench.sv
`include "fpb_map.svh"

module flash_page_buffer_access_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0]  req;
        logic [17:0] addr;
        logic [1:0]  wid;
        logic [31:0] wd;
        logic        grd;
        logic        lck;
        logic [1:0]  st;
        logic [31:0] rd;
        logic [3:0]  lat;
    } fpb_row_t;
    logic              clk_i, sys_rst_i, hold, want, jreq, grant;
    logic              avs_read, avs_write, wait_r, irq;
    fpb_pkg::fpb_req_t req;
    fpb_pkg::fpb_rsp_t rsp;
    logic [3:0]        avs_address, served;
    logic [31:0]       avs_writedata, rdq, rv;
    int                miscompares, checks, n;
    // unused write lanes zero, except the read-over-write priority row with 32'hffffffff
    fpb_row_t rows[22] = '{
        '{8'h08,18'h003,2'h2,32'h44332211,1'b0,1'b0,2'h0,32'h0,4'hb},
        '{8'h08,18'h001,2'h0,32'h000000aa,1'b0,1'b0,2'h0,32'h0,4'h3},
        '{8'h08,18'h003,2'h1,32'h0000ccbb,1'b0,1'b0,2'h0,32'h0,4'h3},
        '{8'h04,18'h002,2'h3,32'h0,1'b0,1'b0,2'h0,32'hccbbaa11,4'h2},
        '{8'h08,18'h010,2'h2,32'h87654321,1'b0,1'b0,2'h0,32'h0,4'h3},
        '{8'h04,18'h010,2'h2,32'h0,1'b0,1'b0,2'h0,32'h87654321,4'h2},
        '{8'h0c,18'h000,2'h2,32'hffffffff,1'b0,1'b0,2'h0,32'hccbbaa11,4'h2},
        '{8'h04,18'h000,2'h2,32'h0,1'b0,1'b0,2'h0,32'hccbbaa11,4'h2},
        '{8'h08,18'h080,2'h2,32'h1,1'b1,1'b0,2'h3,32'h0,4'h0},
        '{8'h20,18'h000,2'h2,32'h0,1'b0,1'b1,2'h0,32'h0,4'h2},
        '{8'h04,18'h000,2'h2,32'h0,1'b0,1'b0,2'h0,32'hccbbaa11,4'h2},
        '{8'h08,18'h000,2'h2,32'h5,1'b0,1'b0,2'h1,32'h0,4'h0},
        '{8'h10,18'h000,2'h2,32'h0,1'b0,1'b0,2'h1,32'h0,4'h0},
        '{8'h20,18'h000,2'h2,32'h0,1'b0,1'b0,2'h1,32'h0,4'h0},
        '{8'h40,18'h000,2'h2,32'h0,1'b0,1'b0,2'h0,32'h0,4'h2},
        '{8'h20,18'h000,2'h2,32'h0,1'b0,1'b0,2'h0,32'h0,4'h2},
        '{8'h08,18'h000,2'h0,32'h00000077,1'b0,1'b0,2'h0,32'h0,4'hb},
        '{8'h04,18'h000,2'h2,32'h0,1'b0,1'b0,2'h0,32'hccbbaa77,4'h2},
        '{8'h80,18'h000,2'h2,32'h0,1'b0,1'b0,2'h0,32'h0,4'h2},
        '{8'h10,18'h000,2'h2,32'h0,1'b0,1'b0,2'h0,32'h0,4'h2},
        '{8'h04,18'h000,2'h2,32'h0,1'b0,1'b0,2'h0,32'h0,4'h2},
        '{8'h08,18'h080,2'h2,32'h12345678,1'b1,1'b0,2'h0,32'h0,4'hb}
    };

    fpb_core dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req), .user_port_hold_i(hold),
        .jtag_req_i(jreq), .jtag_grant_o(grant), .rsp_o(rsp), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(rdq), .avs_waitrequest(wait_r), .irq_o(irq)
    );
    fpb_jtag_model jtag (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .want_i(want), .grant_i(grant),
        .jtag_req_o(jreq), .served_o(served)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t saw %h wanted %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic run_op(input fpb_row_t r);
        @(posedge clk_i);
        req <= '{r.req, r.addr, r.wid, r.wd, r.grd, r.lck};
        @(posedge clk_i);
        req.req <= 8'h00;
        // the take edge counts as the first cycle
        n = 1;
        do begin
            @(posedge clk_i);
            #1;
            n++;
        end while (rsp.done !== 1'b1 && n < 40);
        chk(rsp.done, 1'b1);
        if (r.lat != 4'h0) chk(n, r.lat);
        chk(rsp.busy, 1'b0);
        chk(rsp.status, r.st);
        if (r.req[2]) chk(rsp.rdata, r.rd);
    endtask

    // wait states come from the slave; only the watchdog bounds this wait
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do @(posedge clk_i); while (wait_r !== 1'b0);
        q = rdq;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    initial begin
        #200000;
        miscompares++;
        summarize;
    end

    initial begin
        {hold, want, avs_read, avs_write, avs_address, avs_writedata} = '0;
        req = '0;
        sys_rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        foreach (rows[i]) run_op(rows[i]);
        av(1'b0, 4'h0, 32'h0, rv);
        chk(rv[2:0], 3'h7);
        av(1'b0, 4'h2, 32'h0, rv);
        chk(rv[3:0], 4'h8);
        av(1'b0, 4'h5, 32'h0, rv);
        chk(rv, 32'h0);
        av(1'b1, 4'h1, 32'h7, rv);
        repeat (3) @(posedge clk_i);
        chk(irq, 1'b0);
        av(1'b1, 4'h1, 32'h0, rv);
        repeat (3) @(posedge clk_i);
        chk(irq, 1'b1);
        av(1'b1, 4'h0, 32'h7, rv);
        repeat (3) @(posedge clk_i);
        chk(irq, 1'b0);
        av(1'b0, 4'h0, 32'h0, rv);
        chk(rv[2:0], 3'h0);
        hold <= 1'b1;
        want <= 1'b1;
        repeat (12) @(posedge clk_i);
        chk(grant, 1'b0);
        hold <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk(grant, 1'b1);
        @(posedge clk_i);
        want <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(served, 4'h1);
        chk(grant, 1'b0);
        req <= '{8'h08, 18'h180, 2'h2, 32'h0, 1'b0, 1'b0};
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b1;
        req.req   <= 8'h00;
        #1;
        chk({rsp.busy, rsp.done, grant, irq, wait_r}, 32'h1);
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        av(1'b0, 4'h0, 32'h0, rv);
        chk(rv[2:0], 3'h0);
        run_op('{8'h08, 18'h180, 2'h2, 32'h9, 1'b0, 1'b0, 2'h0, 32'h0, 4'hb});
        summarize;
    end
endmodule // flash_page_buffer_access_bench
